// File: logic/pph_port_timer.sv
// Contract
// - direction bit 0 input, 1 output
// - output pin follows its output latch bit
// - latch writes stored while pin is input
// - port A reads live or A1-latched levels
// - port B outputs read latch, A reads pin
// - port B latched inputs captured on B1
// - A handshakes both ways, B writes only
// - A1 data-ready strobe sets a flag
// - A2 data-taken on port A read
// - line 2 data-ready cleared by line 1
// - line modes chosen by line config register
// - timer: two latches, counter decrements each cycle
// - zero sets timer flag, interrupt if enabled
// - continuous mode reloads from latches at zero
// - high counter write clears flag, loads, starts
// - one-shot high latch write leaves count alone
// - bit 7 pulse low from load to time-out
// - counter keeps counting after one-shot time-out
// - one-shot flag sets once per load
// - reset clears control, ports input, irq off
// - select 15 is port A without handshake
// - low counter read clears timer flag
// - bit 7 timer drive needs direction and enable
`timescale 1ns/100ps
module pph_port_timer
	import pph_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_cs1,
	input wire logic i_cs2_n,
	input wire logic i_rw,
	input wire logic [3:0] i_rs,
	input wire logic [7:0] i_db,
	output logic [7:0] o_db,
	output logic o_db_oe,
	input wire logic [7:0] i_pa,
	output logic [7:0] o_pa,
	output logic [7:0] o_pa_oe,
	input wire logic i_ca1,
	input wire logic i_ca2,
	output logic o_ca2,
	output logic o_ca2_oe,
	input wire logic [7:0] i_pb,
	output logic [7:0] o_pb,
	output logic [7:0] o_pb_oe,
	input wire logic i_cb1,
	input wire logic i_cb2,
	output logic o_cb2,
	output logic o_cb2_oe,
	output logic o_irq_pull_low,
	output logic o_pa_capture_ready
);
	pph_bus_req_type req;
	logic acc_a, acc_b, rd_a_hs, wr_b;

	logic [7:0] ora_q, ora_d, orb_q, orb_d, port_a_direction_q, port_a_direction_d, port_b_direction_q, port_b_direction_d;
	logic [7:0] acr_q, acr_d, pcr_q, pcr_d;
	logic [6:0] ier_q, ier_d;

	logic ca1_prev_q, ca1_prev_d, cb1_prev_q, cb1_prev_d, a1_edge, b1_edge;
	logic a2_set, a2_clr, b2_set, b2_clr;

	logic [7:0] ifr_q, ifr_d, flg_set, flg_clr;

	logic [7:0] t1_lo_q, t1_lo_d, t1_hi_q, t1_hi_d;
	logic [CNT_W-1:0] t1_cnt_q, t1_cnt_d;
	logic t1_armed_q, t1_armed_d, t1_wave_q, t1_wave_d, t1_fire, t1_clr;

	logic [7:0] irb_q, irb_d, pa_hold_q, pa_hold_d;
	logic fifo_push, fifo_in_ready, fifo_valid, fifo_pop;
	logic [7:0] fifo_head, pa_in_val, pb_in_val;

	logic [7:0] rdata_q, rdata_d, pb_q, pb_d;
	logic db_oe_q, db_oe_d, irq_q, irq_d, cap_rdy_q, cap_rdy_d;

	// bus decode; one access per clock while selected
	always_comb
	begin
		req.rd = i_cs1 & ~i_cs2_n & i_rw;
		req.wr = i_cs1 & ~i_cs2_n & ~i_rw;
		req.rs = i_rs;
		req.wdata = i_db;
		acc_a = (req.rd | req.wr) & (req.rs == REG_PORT_A);
		acc_b = (req.rd | req.wr) & (req.rs == REG_PORT_B);
		rd_a_hs = req.rd & (req.rs == REG_PORT_A);
		wr_b = req.wr & (req.rs == REG_PORT_B);
	end

	// control registers
	always_comb
	begin
		ora_d = ora_q;
		orb_d = orb_q;
		port_a_direction_d = port_a_direction_q;
		port_b_direction_d = port_b_direction_q;
		acr_d = acr_q;
		pcr_d = pcr_q;
		ier_d = ier_q;
		if (req.wr)
		begin
			case (req.rs)
				REG_PORT_B: orb_d = req.wdata;
				REG_PORT_A, REG_PORT_A_QUIET: ora_d = req.wdata;
				REG_DIR_B: port_b_direction_d = req.wdata;
				REG_DIR_A: port_a_direction_d = req.wdata;
				REG_AUX: acr_d = req.wdata;
				REG_LINE_CFG: pcr_d = req.wdata;
				REG_ENABLES:
					ier_d = req.wdata[ENA_SET] ? (ier_q | req.wdata[6:0])
						: (ier_q & ~req.wdata[6:0]);
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			ora_q <= REG_RESET;
			orb_q <= REG_RESET;
			port_a_direction_q <= REG_RESET;
			port_b_direction_q <= REG_RESET;
			acr_q <= REG_RESET;
			pcr_q <= REG_RESET;
			ier_q <= REG_RESET[6:0];
		end
		else
		begin
			ora_q <= ora_d;
			orb_q <= orb_d;
			port_a_direction_q <= port_a_direction_d;
			port_b_direction_q <= port_b_direction_d;
			acr_q <= acr_d;
			pcr_q <= pcr_d;
			ier_q <= ier_d;
		end
	end

	// first control lines: edge detect with selectable polarity
	always_comb
	begin
		ca1_prev_d = i_ca1;
		cb1_prev_d = i_cb1;
		a1_edge = pph_active_edge(pcr_q[CFG_A1_POL], ca1_prev_q, i_ca1);
		b1_edge = pph_active_edge(pcr_q[CFG_B1_POL], cb1_prev_q, i_cb1);
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			ca1_prev_q <= 1'b0;
			cb1_prev_q <= 1'b0;
		end
		else
		begin
			ca1_prev_q <= ca1_prev_d;
			cb1_prev_q <= cb1_prev_d;
		end
	end

	// port A line 2 handshakes on reads and writes of the port
	pph_hs_line u_a2 (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_mode(pcr_q[CFG_A2_LSB +: CFG_L2_W]),
		.i_line_in(i_ca2),
		.i_trigger(acc_a),
		.i_access(acc_a),
		.i_done(a1_edge),
		.o_line(o_ca2),
		.o_oe(o_ca2_oe),
		.o_flag_set(a2_set),
		.o_flag_clr(a2_clr)
	);

	// port B line 2 handshakes on writes only
	pph_hs_line u_b2 (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_mode(pcr_q[CFG_B2_LSB +: CFG_L2_W]),
		.i_line_in(i_cb2),
		.i_trigger(wr_b),
		.i_access(acc_b),
		.i_done(b1_edge),
		.o_line(o_cb2),
		.o_oe(o_cb2_oe),
		.o_flag_set(b2_set),
		.o_flag_clr(b2_clr)
	);

	// flags: a set in the same cycle as a clear wins
	always_comb
	begin
		flg_set = '0;
		flg_set[FLG_A1] = a1_edge;
		flg_set[FLG_B1] = b1_edge;
		flg_set[FLG_A2] = a2_set;
		flg_set[FLG_B2] = b2_set;
		flg_set[FLG_T1] = t1_fire;
		flg_clr = '0;
		if (req.wr && req.rs == REG_FLAGS)
			flg_clr = req.wdata;
		flg_clr[FLG_A1] = flg_clr[FLG_A1] | acc_a;
		flg_clr[FLG_A2] = flg_clr[FLG_A2] | a2_clr;
		flg_clr[FLG_B1] = flg_clr[FLG_B1] | acc_b;
		flg_clr[FLG_B2] = flg_clr[FLG_B2] | b2_clr;
		flg_clr[FLG_T1] = flg_clr[FLG_T1] | t1_clr;
		ifr_d = ((ifr_q & ~flg_clr) | flg_set) & FLAG_IMPL_MASK;
		irq_d = |(ifr_q[6:0] & ier_q);
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			ifr_q <= REG_RESET;
			irq_q <= 1'b0;
		end
		else
		begin
			ifr_q <= ifr_d;
			irq_q <= irq_d;
		end
	end

	// timer one; latches and counter are not cleared by reset, and the counter keeps decrementing through it
	always_comb
	begin
		t1_lo_d = t1_lo_q;
		t1_hi_d = t1_hi_q;
		t1_armed_d = t1_armed_q;
		t1_wave_d = t1_wave_q;
		t1_cnt_d = t1_cnt_q - 1'b1;
		t1_clr = (req.wr && req.rs == REG_T1_HI) || (req.rd && req.rs == REG_T1_LO);
		t1_fire = (t1_cnt_q == '0) & (t1_armed_q | acr_q[AUX_T1_CONT]);
		if (t1_fire)
		begin
			t1_armed_d = 1'b0;
			t1_wave_d = acr_q[AUX_T1_CONT] ? ~t1_wave_q : 1'b1;
		end
		if (t1_cnt_q == '0 && acr_q[AUX_T1_CONT])
			t1_cnt_d = {t1_hi_q, t1_lo_q};
		if (req.wr)
		begin
			case (req.rs)
				REG_T1_LO, REG_T1_LATCH_LO: t1_lo_d = req.wdata;
				REG_T1_LATCH_HI: t1_hi_d = req.wdata;
				REG_T1_HI:
				begin
					t1_hi_d = req.wdata;
					t1_cnt_d = {req.wdata, t1_lo_q};
					t1_armed_d = 1'b1;
					t1_wave_d = 1'b0;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		t1_lo_q <= t1_lo_d;
		t1_hi_q <= t1_hi_d;
		t1_cnt_q <= t1_cnt_d;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			t1_armed_q <= 1'b0;
			t1_wave_q <= 1'b1;
		end
		else
		begin
			t1_armed_q <= t1_armed_d;
			t1_wave_q <= t1_wave_d;
		end
	end

	// latched port A captures queue up so a burst of up to FIFO_DEPTH strobes is not lost
	always_comb
	begin
		fifo_push = a1_edge & acr_q[AUX_PA_LATCH];
		fifo_pop = rd_a_hs & acr_q[AUX_PA_LATCH] & fifo_valid;
		pa_hold_d = fifo_pop ? fifo_head : pa_hold_q;
		irb_d = b1_edge ? i_pb : irb_q;
		cap_rdy_d = fifo_in_ready;
	end

	pph_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_pa_fifo (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_valid(fifo_push),
		.o_ready(fifo_in_ready),
		.i_data(i_pa),
		.o_valid(fifo_valid),
		.i_ready(fifo_pop),
		.o_data(fifo_head)
	);

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			pa_hold_q <= REG_RESET;
			irb_q <= REG_RESET;
			cap_rdy_q <= 1'b0;
		end
		else
		begin
			pa_hold_q <= pa_hold_d;
			irb_q <= irb_d;
			cap_rdy_q <= cap_rdy_d;
		end
	end

	// read data and pin drive
	always_comb
	begin
		pa_in_val = i_pa;
		if (acr_q[AUX_PA_LATCH])
			pa_in_val = fifo_valid ? fifo_head : pa_hold_q;
		pb_in_val = acr_q[AUX_PB_LATCH] ? irb_q : i_pb;
		rdata_d = '0;
		case (req.rs)
			REG_PORT_B: rdata_d = pph_by_dir(port_b_direction_q, orb_q, pb_in_val);
			REG_PORT_A, REG_PORT_A_QUIET: rdata_d = pph_by_dir(port_a_direction_q, i_pa, pa_in_val);
			REG_DIR_B: rdata_d = port_b_direction_q;
			REG_DIR_A: rdata_d = port_a_direction_q;
			REG_T1_LO: rdata_d = t1_cnt_q[7:0];
			REG_T1_HI: rdata_d = t1_cnt_q[15:8];
			REG_T1_LATCH_LO: rdata_d = t1_lo_q;
			REG_T1_LATCH_HI: rdata_d = t1_hi_q;
			REG_AUX: rdata_d = acr_q;
			REG_LINE_CFG: rdata_d = pcr_q;
			REG_FLAGS:
			begin
				rdata_d = ifr_q;
				rdata_d[FLG_ANY] = |(ifr_q[6:0] & ier_q);
			end
			REG_ENABLES: rdata_d = {1'b0, ier_q};
			default: rdata_d = '0;
		endcase
		if (!req.rd)
			rdata_d = '0;
		db_oe_d = req.rd;
		pb_d = orb_q;
		if (port_b_direction_q[7] && acr_q[AUX_T1_OUT])
			pb_d[7] = t1_wave_q;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			rdata_q <= REG_RESET;
			db_oe_q <= 1'b0;
			pb_q <= REG_RESET;
		end
		else
		begin
			rdata_q <= rdata_d;
			db_oe_q <= db_oe_d;
			pb_q <= pb_d;
		end
	end

	always_comb
	begin
		o_db = rdata_q;
		o_db_oe = db_oe_q;
		o_pa = ora_q;
		o_pa_oe = port_a_direction_q;
		o_pb = pb_q;
		o_pb_oe = port_b_direction_q;
		o_irq_pull_low = irq_q;
		o_pa_capture_ready = cap_rdy_q;
	end
endmodule

// File: logic/pph_pkg.sv
package pph_pkg;

	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam int FIFO_DEPTH_DEF = 8;

	localparam logic [3:0] REG_PORT_B = 4'h0;
	localparam logic [3:0] REG_PORT_A = 4'h1;
	localparam logic [3:0] REG_DIR_B = 4'h2;
	localparam logic [3:0] REG_DIR_A = 4'h3;
	localparam logic [3:0] REG_T1_LO = 4'h4;
	localparam logic [3:0] REG_T1_HI = 4'h5;
	localparam logic [3:0] REG_T1_LATCH_LO = 4'h6;
	localparam logic [3:0] REG_T1_LATCH_HI = 4'h7;
	localparam logic [3:0] REG_AUX = 4'hb;
	localparam logic [3:0] REG_LINE_CFG = 4'hc;
	localparam logic [3:0] REG_FLAGS = 4'hd;
	localparam logic [3:0] REG_ENABLES = 4'he;
	localparam logic [3:0] REG_PORT_A_QUIET = 4'hf;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] FLAG_IMPL_MASK = 8'h5b;

	// auxiliary_control fields
	localparam int AUX_PA_LATCH = 0;
	localparam int AUX_PB_LATCH = 1;
	localparam int AUX_T1_CONT = 6;
	localparam int AUX_T1_OUT = 7;

	// control_line_config fields
	localparam int CFG_A1_POL = 0;
	localparam int CFG_A2_LSB = 1;
	localparam int CFG_B1_POL = 4;
	localparam int CFG_B2_LSB = 5;
	localparam int CFG_L2_W = 3;

	// second control line modes
	localparam logic [2:0] L2_IN_NEG = 3'h0;
	localparam logic [2:0] L2_IN_NEG_IND = 3'h1;
	localparam logic [2:0] L2_IN_POS = 3'h2;
	localparam logic [2:0] L2_IN_POS_IND = 3'h3;
	localparam logic [2:0] L2_HANDSHAKE = 3'h4;
	localparam logic [2:0] L2_PULSE = 3'h5;
	localparam logic [2:0] L2_LOW = 3'h6;
	localparam logic [2:0] L2_HIGH = 3'h7;
	localparam int L2_OUT_BIT = 2;
	localparam int L2_POS_BIT = 1;
	localparam int L2_IND_BIT = 0;

	// flag and enable bit positions
	localparam int FLG_A2 = 0;
	localparam int FLG_A1 = 1;
	localparam int FLG_B2 = 3;
	localparam int FLG_B1 = 4;
	localparam int FLG_T1 = 6;
	localparam int FLG_ANY = 7;
	localparam int ENA_SET = 7;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] rs;
		logic [7:0] wdata;
	} pph_bus_req_type;

	function automatic logic pph_active_edge(input logic pos, input logic prev, input logic cur);
		return pos ? (~prev & cur) : (prev & ~cur);
	endfunction

	function automatic logic [7:0] pph_by_dir(input logic [7:0] dir, input logic [7:0] out_val,
		input logic [7:0] in_val);
		return (dir & out_val) | (~dir & in_val);
	endfunction

endpackage

// File: logic/pph_fifo.sv
`timescale 1ns/100ps
module pph_fifo
	import pph_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH_DEF
)
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	always_comb
	begin
		o_ready = cnt_q != FULL_CNT;
		o_valid = cnt_q != '0;
		o_data = mem_q[rd_q];
		push = i_valid & o_ready;
		pop = o_valid & i_ready;
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		if (push)
		begin
			mem_d[wr_q] = i_data;
			wr_d = (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
		end
		if (pop)
			rd_d = (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_mclk)
	begin
		mem_q <= mem_d;
		if (!i_rstn)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

// File: logic/pph_hs_line.sv
`timescale 1ns/100ps
module pph_hs_line
	import pph_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [2:0] i_mode,
	input wire logic i_line_in,
	input wire logic i_trigger,
	input wire logic i_access,
	input wire logic i_done,
	output logic o_line,
	output logic o_oe,
	output logic o_flag_set,
	output logic o_flag_clr
);
	logic prev_q, prev_d, out_q, out_d;

	always_comb
	begin
		prev_d = i_line_in;
		o_oe = i_mode[L2_OUT_BIT];
		o_flag_set = ~i_mode[L2_OUT_BIT] & pph_active_edge(i_mode[L2_POS_BIT], prev_q, i_line_in);
		// independent input mode leaves the flag alone on port access
		o_flag_clr = i_access & ~(~i_mode[L2_OUT_BIT] & i_mode[L2_IND_BIT]);
		o_line = out_q;
		out_d = 1'b1;
		case (i_mode)
			L2_HANDSHAKE:
			begin
				out_d = out_q;
				if (i_done)
					out_d = 1'b1;
				if (i_trigger)
					out_d = 1'b0;
			end
			L2_PULSE: out_d = ~i_trigger;
			L2_LOW: out_d = 1'b0;
			default: out_d = 1'b1;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			prev_q <= 1'b0;
			out_q <= 1'b1;
		end
		else
		begin
			prev_q <= prev_d;
			out_q <= out_d;
		end
	end
endmodule

// File: test/pph_port_timer_chk.sv
`timescale 1ns/100ps
module pph_port_timer_chk
	import pph_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_cs1,
	input wire logic i_cs2_n,
	input wire logic i_rw,
	input wire logic [3:0] i_rs,
	input wire logic [7:0] i_db,
	input wire logic [7:0] o_db,
	input wire logic [7:0] o_pa,
	input wire logic [7:0] o_pa_oe,
	input wire logic [7:0] i_pb,
	input wire logic [7:0] o_pb,
	input wire logic [7:0] o_pb_oe,
	input wire logic i_cb1,
	input wire logic o_ca2,
	input wire logic o_cb2,
	input wire logic o_irq_pull_low
);
	logic wr, rd;
	logic [2:0] a2m, b2m;
	logic [7:0] r_q [16];
	assign wr = i_cs1 && !i_cs2_n && !i_rw;
	assign rd = i_cs1 && !i_cs2_n && i_rw;
	assign a2m = r_q[REG_LINE_CFG][CFG_A2_LSB+:CFG_L2_W];
	assign b2m = r_q[REG_LINE_CFG][CFG_B2_LSB+:CFG_L2_W];
	// shadow of written registers; select 15 shares the port A latch
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			for (int i = 0; i < 16; i++)
			begin
				r_q[i] <= REG_RESET;
			end
		end
		else if (wr)
		begin
			r_q[(i_rs == REG_PORT_A_QUIET) ? REG_PORT_A : i_rs] <= i_db;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	sequence s_pulse_a;
		!o_ca2 ##1 o_ca2;
	endsequence
	chk_reset_idle:
	assert property ($rose(i_rstn) |-> o_pa_oe == 8'h00 && o_pb_oe == 8'h00 && !o_irq_pull_low)
		else $error("ports not idle after reset");
	chk_dir_a:
	assert property (wr && i_rs == REG_DIR_A |=> ##1 o_pa_oe == r_q[REG_DIR_A])
		else $error("port A enables differ from direction");
	chk_dir_b:
	assert property (wr && i_rs == REG_DIR_B |=> ##1 o_pb_oe == r_q[REG_DIR_B])
		else $error("port B enables differ from direction");
	chk_latch_a:
	assert property (wr && i_rs == REG_PORT_A |=> ##1 o_pa == r_q[REG_PORT_A])
		else $error("port A drive differs from latch");
	chk_read_b:
	assert property (rd && i_rs == REG_PORT_B && !r_q[REG_AUX][AUX_PB_LATCH] |=>
		o_db == ((r_q[REG_DIR_B] & r_q[REG_PORT_B]) | (~r_q[REG_DIR_B] & $past(i_pb))))
		else $error("port B read wrong");
	chk_pulse_a:
	assert property (rd && i_rs == REG_PORT_A && a2m == L2_PULSE |=> s_pulse_a)
		else $error("A2 pulse not one cycle");
	chk_taken_a:
	assert property (rd && i_rs == REG_PORT_A && a2m == L2_HANDSHAKE |=> !o_ca2)
		else $error("A2 not low after read");
	chk_quiet_a:
	assert property (rd && i_rs == REG_PORT_A_QUIET && a2m == L2_HANDSHAKE && o_ca2 |=> o_ca2)
		else $error("select 15 moved A2");
	chk_ready_b:
	assert property (wr && i_rs == REG_PORT_B && b2m == L2_HANDSHAKE |=> !o_cb2)
		else $error("B2 not low after write");
	chk_taken_b:
	assert property (b2m == L2_HANDSHAKE && !r_q[REG_LINE_CFG][CFG_B1_POL] && $fell(i_cb1)
		&& !(wr && i_rs == REG_PORT_B) |=> o_cb2)
		else $error("B2 not released by B1");
	chk_pulse_b7:
	assert property (wr && i_rs == REG_T1_HI && i_db != 8'h00 && r_q[REG_AUX][AUX_T1_OUT]
		&& r_q[REG_DIR_B][7] |-> ##2 !o_pb[7])
		else $error("bit 7 not low after load");
endmodule
bind pph_port_timer pph_port_timer_chk u_chk (.i_mclk, .i_rstn, .i_cs1, .i_cs2_n, .i_rw,
	.i_rs, .i_db, .o_db, .o_pa, .o_pa_oe, .i_pb, .o_pb, .o_pb_oe, .i_cb1, .o_ca2, .o_cb2,
	.o_irq_pull_low);

// File: test/pph_periph.sv
`timescale 1ns/100ps
module pph_periph
(
	input wire logic i_mclk,
	input wire logic [7:0] i_drv_a,
	input wire logic [7:0] i_drv_b,
	input wire logic i_send,
	input wire logic [3:0] i_lag,
	input wire logic [7:0] i_pa_out,
	input wire logic [7:0] i_pa_oe,
	input wire logic [7:0] i_pb_out,
	input wire logic [7:0] i_pb_oe,
	input wire logic i_ready_b,
	output logic [7:0] o_pa,
	output logic [7:0] o_pb,
	output logic o_ca1,
	output logic o_cb1
);
	logic ca1_q = 1'b1, cb1_q = 1'b1, rdy_q = 1'b1;
	logic [4:0] wait_q = 5'h00;
	// the device wins on bits it drives, the peripheral holds the rest
	assign o_pa = (i_pa_oe & i_pa_out) | (~i_pa_oe & i_drv_a);
	assign o_pb = (i_pb_oe & i_pb_out) | (~i_pb_oe & i_drv_b);
	assign o_ca1 = ca1_q;
	assign o_cb1 = cb1_q;
	always @(posedge i_mclk)
	begin
		ca1_q <= !i_send;
		rdy_q <= i_ready_b;
		cb1_q <= (wait_q != 5'h01);
		if (rdy_q && !i_ready_b)
			wait_q <= {1'b0, i_lag} + 5'h01;
		else if (wait_q != 5'h00)
			wait_q <= wait_q - 5'h01;
	end
endmodule

// File: test/pph_port_timer_tb_top.sv
`timescale 1ns/100ps
module pph_port_timer_tb_top
	import pph_pkg::*;
;
	logic i_mclk = 1'b0, i_rstn = 1'b0, cs1 = 1'b0, rw = 1'b1, send = 1'b0;
	logic [3:0] rs = 4'h0, lag = 4'h0;
	logic [7:0] db = 8'h00, ext_a = 8'h00, ext_b = 8'h00, rd_v, o_db, pa, pb;
	logic [7:0] pa_o, pa_oe, pb_o, pb_oe;
	logic [7:0] v [6];
	logic ca1, cb1, ca2, ca2_oe, cb2, cb2_oe, irq, db_oe, cap_rdy;
	logic [31:0] seed = 32'hda0e;
	int fail_count = 0, checks_done = 0, cyc = 0, n;
	always #12.5 i_mclk = ~i_mclk;
	pph_port_timer dut (.i_mclk, .i_rstn, .i_cs1(cs1), .i_cs2_n(1'b0), .i_rw(rw), .i_rs(rs),
		.i_db(db), .o_db, .o_db_oe(db_oe), .i_pa(pa), .o_pa(pa_o), .o_pa_oe(pa_oe), .i_ca1(ca1),
		.i_ca2(ca2_oe ? ca2 : 1'b1), .o_ca2(ca2), .o_ca2_oe(ca2_oe), .i_pb(pb), .o_pb(pb_o),
		.o_pb_oe(pb_oe), .i_cb1(cb1), .i_cb2(cb2_oe ? cb2 : 1'b1), .o_cb2(cb2),
		.o_cb2_oe(cb2_oe), .o_irq_pull_low(irq), .o_pa_capture_ready(cap_rdy));
	pph_periph u_per (.i_mclk, .i_drv_a(ext_a), .i_drv_b(ext_b), .i_send(send), .i_lag(lag),
		.i_pa_out(pa_o), .i_pa_oe(pa_oe), .i_pb_out(pb_o), .i_pb_oe(pb_oe), .i_ready_b(cb2),
		.o_pa(pa), .o_pb(pb), .o_ca1(ca1), .o_cb1(cb1));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d = 8'h00);
		@(posedge i_mclk);
		cs1 <= 1'b1;
		rw <= r;
		rs <= a;
		db <= d;
		@(posedge i_mclk);
		cs1 <= 1'b0;
		#1;
		rd_v = o_db;
	endtask
	// data must sit on the pins before the peripheral strobes
	task automatic strobe();
		@(posedge i_mclk);
		send <= 1'b1;
		@(posedge i_mclk);
		send <= 1'b0;
		repeat (3) @(posedge i_mclk);
	endtask
	task automatic wait_for(input logic sel, input int lim);
		n = 0;
		do
		begin
			@(posedge i_mclk);
			#1;
			n++;
		end
		while ((sel ? cb2 : irq) !== 1'b1 && n < lim);
	endtask
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (4) @(posedge i_mclk);
		i_rstn <= 1'b1;
		#1;
		chk("pa_oe", pa_oe, 8'h00);
		chk("irq", irq, 1'b0);
		acc(1'b1, REG_DIR_B);
		chk("dir_b", rd_v, 8'h00);
		chk("db_oe", db_oe, 1'b1);
		chk("cap_rdy", cap_rdy, 1'b1);
		repeat (4)
		begin
			foreach (v[i]) v[i] = rnd();
			ext_a <= v[4];
			ext_b <= v[5];
			acc(1'b0, REG_PORT_A, v[0]);
			acc(1'b0, REG_DIR_A, v[1]);
			acc(1'b0, REG_PORT_B, v[2]);
			acc(1'b0, REG_DIR_B, v[3]);
			acc(1'b1, REG_PORT_A);
			chk("port_a", rd_v, (v[1] & v[0]) | (~v[1] & v[4]));
			acc(1'b1, REG_PORT_B);
			chk("port_b", rd_v, (v[3] & v[2]) | (~v[3] & v[5]));
			chk("pa_oe", pa_oe, v[1]);
			chk("pa", pa_o, v[0]);
		end
		acc(1'b0, REG_DIR_A);
		acc(1'b0, REG_AUX, 8'h01);
		acc(1'b0, REG_LINE_CFG, {4'h0, L2_HANDSHAKE, 1'b0});
		ext_a <= 8'h3c;
		strobe();
		ext_a <= 8'hc3;
		acc(1'b1, REG_FLAGS);
		chk("flag_a1", rd_v[FLG_A1], 1'b1);
		acc(1'b1, REG_PORT_A);
		chk("latched", rd_v, 8'h3c);
		chk("taken", ca2, 1'b0);
		strobe();
		chk("taken_end", ca2, 1'b1);
		acc(1'b1, REG_PORT_A_QUIET);
		chk("quiet", ca2, 1'b1);
		acc(1'b0, REG_LINE_CFG, {4'h0, L2_PULSE, 1'b0});
		acc(1'b1, REG_PORT_A);
		chk("pulse", ca2, 1'b0);
		acc(1'b0, REG_LINE_CFG, {L2_HANDSHAKE, 5'h00});
		for (int k = 0; k < 2; k++)
		begin
			lag <= 4'(k * 7);
			acc(1'b0, REG_PORT_B, rnd());
			chk("ready_b", cb2, 1'b0);
			wait_for(1'b1, 20);
			chk("taken_b", n < 20, 1'b1);
			acc(1'b1, REG_FLAGS);
			chk("flag_b1", rd_v[FLG_B1], 1'b1);
			acc(1'b0, REG_FLAGS, 8'h18);
		end
		acc(1'b0, REG_ENABLES, 8'hc0);
		acc(1'b0, REG_DIR_B, 8'h80);
		acc(1'b0, REG_AUX, 8'h80);
		acc(1'b0, REG_T1_LO, 8'h20);
		acc(1'b0, REG_T1_HI, 8'h01);
		wait_for(1'b0, 400);
		chk("t1_time", n >= 288 && n <= 290, 1'b1);
		chk("b7_high", pb_o[7], 1'b1);
		acc(1'b1, REG_T1_LO);
		n = rd_v;
		acc(1'b1, REG_T1_LO);
		chk("t1_runs", 8'(n - rd_v), 8'h02);
		chk("t1_clear", irq, 1'b0);
		acc(1'b0, REG_AUX, 8'h40);
		acc(1'b0, REG_T1_LO, 8'h10);
		acc(1'b0, REG_T1_HI, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			wait_for(1'b0, 40);
			chk("t1_again", n < 40, 1'b1);
			acc(1'b0, REG_FLAGS, 8'h40);
		end
		report_and_stop();
	end
endmodule
